// ### hdl/asps_switch.sv
`timescale 1ns/1ps
`default_nettype none
module asps_switch #(
  parameter int ADDR_WIDTH = 10
) (
  input  wire logic                         clk_in,
  input  wire logic                         reset_n_in,
  input  wire asps_pkg::asps_primary_in_s   primary_in,
  input  wire logic                         secondary_data_in,
  input  wire logic                         force_connect_n_in,
  input  wire logic [ADDR_WIDTH-1:0]        board_address_straps_in,
  output var  asps_pkg::asps_primary_out_s  primary_out,
  output var  asps_pkg::asps_secondary_out_s secondary_out,
  output var  logic                         connected_n_out
);
  import asps_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: every pin is foreign to clk_in

  // Four primary pins, secondary data in and the straps share one synchroniser
  localparam int SW = ADDR_WIDTH + 5;

  logic [SW-1:0] sync_stage1;
  logic [SW-1:0] sync_stage2;
  logic          clock_prev;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_stage1 <= '0;
      sync_stage2 <= '0;
      clock_prev  <= 1'b0;
    end else begin
      sync_stage1 <= {primary_in, secondary_data_in, board_address_straps_in};
      sync_stage2 <= sync_stage1;
      clock_prev  <= sync_stage2[SW-1];
    end
  end

  wire                  s_clock      = sync_stage2[SW-1];
  wire                  s_reset_n    = sync_stage2[SW-2];
  wire                  s_tms        = sync_stage2[SW-3];
  wire                  s_tdi        = sync_stage2[SW-4];
  wire                  s_sdi        = sync_stage2[ADDR_WIDTH];
  wire [ADDR_WIDTH-1:0] s_straps     = sync_stage2[ADDR_WIDTH-1:0];
  wire                  clock_rise   = s_clock & ~clock_prev;
  wire                  clock_fall   = ~s_clock & clock_prev;

  // Force-connect is asynchronous to the test clock, but it must still pass two
  // flops; the added latency of two clk_in cycles is far below a test clock period.
  logic byp_stage1;
  logic byp_stage2;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byp_stage1 <= 1'b1;
      byp_stage2 <= 1'b1;
    end else begin
      byp_stage1 <= force_connect_n_in;
      byp_stage2 <= byp_stage1;
    end
  end

  wire bypass = ~byp_stage2;

  //////////////////////////////////////////////////////////////////////////////
  // Primary controller state tracking

  function automatic asps_tap_e tap_next(input asps_tap_e cur, input logic tms);
    case (cur)
      TAP_RESET:    tap_next = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   tap_next = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   tap_next = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      tap_next = TAP_RESET;
    endcase
  endfunction

  function automatic logic is_pause(input asps_tap_e st);
    is_pause = (st == TAP_PAUSE_DR) || (st == TAP_PAUSE_IR);
  endfunction

  asps_tap_e tap_state;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tap_state <= TAP_RESET;
    end else if (!s_reset_n) begin
      tap_state <= TAP_RESET;
    end else if (clock_rise) begin
      tap_state <= tap_next(tap_state, s_tms);
    end
  end

  // Only reset, idle and the two pause states; the shift states also loop back but do not count
  wire stable_state = (tap_state == TAP_RESET) || (tap_state == TAP_IDLE) ||
                      is_pause(tap_state);

  //////////////////////////////////////////////////////////////////////////////
  // Shadow protocol receiver and acknowledge

  asps_proto_e          proto;
  asps_status_e         status;
  logic [3:0]           bit_count;
  logic                 half;
  logic                 first_bit;
  logic                 ref_tms;
  logic [ADDR_WIDTH-1:0] rx_addr;
  logic [4:0]           ack_step;
  logic                 ack_bit;
  logic                 ack_oe;
  logic                 sync_ok;

  wire [ADDR_WIDTH-1:0] full_addr = {rx_addr[ADDR_WIDTH-2:0], first_bit};
  wire                  last_pair = (bit_count == LAST_BIT);
  wire                  tms_moved = (s_tms != ref_tms);
  wire                  pair_bad  = (s_tdi == first_bit);
  wire                  hit_reset = (full_addr == RESET_CODE);
  wire                  hit_disc  = (full_addr == DISCONN_CODE);
  wire                  hit_sync  = (full_addr == SYNC_CODE);
  wire                  hit_own   = (full_addr == s_straps);
  wire                  ack_done  = (ack_step == ACK_STEPS);
  wire [3:0]            ack_index = ack_step[4:1];
  wire                  ack_value = s_straps[LAST_BIT - ack_index] ^ ack_step[0];

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      proto     <= P_IDLE;
      status    <= ST_RESET;
      bit_count <= 4'h0;
      half      <= 1'b0;
      first_bit <= 1'b0;
      ref_tms   <= 1'b0;
      rx_addr   <= ADDR_RESET;
      ack_step  <= 5'h00;
      ack_bit   <= 1'b0;
      ack_oe    <= 1'b0;
      sync_ok   <= 1'b0;
    end else if (!s_reset_n) begin
      proto     <= P_IDLE;
      status    <= ST_RESET;
      ack_oe    <= 1'b0;
    end else if (bypass) begin
      proto     <= P_IDLE;
      ack_oe    <= 1'b0;
    end else begin
      case (proto)
        P_IDLE: begin
          // A low start bit opens a frame
          if (clock_rise && stable_state && !s_tdi) begin
            proto     <= P_ADDR;
            bit_count <= 4'h0;
            half      <= 1'b0;
            ref_tms   <= s_tms;
            sync_ok   <= is_pause(tap_state);
          end
        end
        P_ADDR: begin
          if (clock_rise) begin
            if (tms_moved) begin
              proto  <= P_IDLE;
              status <= ST_OFF;
            end else if (!half) begin
              first_bit <= s_tdi;
              half      <= 1'b1;
            end else if (pair_bad) begin
              proto  <= P_IDLE;
              status <= ST_OFF;
            end else begin
              half    <= 1'b0;
              rx_addr <= full_addr;
              if (last_pair) begin
                proto <= P_IDLE;
                if (hit_reset) begin
                  status <= ST_RESET;
                end else if (hit_disc) begin
                  status <= ST_OFF;
                end else if (hit_sync) begin
                  if (sync_ok) begin
                    status <= ST_MULTI;
                  end
                end else if (hit_own) begin
                  proto    <= P_ACK;
                  ack_step <= 5'h00;
                end else begin
                  status <= ST_OFF;
                end
              end else begin
                bit_count <= bit_count + 4'h1;
              end
            end
          end
        end
        P_ACK: begin
          // Pairs of own address and its inverse, MSB first, on falling edges
          if (clock_rise && tms_moved) begin
            proto  <= P_IDLE;
            ack_oe <= 1'b0;
            status <= ST_OFF;
          end else if (clock_fall) begin
            if (ack_done) begin
              proto  <= P_IDLE;
              ack_oe <= 1'b0;
              status <= ST_ON;
            end else begin
              ack_bit  <= ack_value;
              ack_oe   <= 1'b1;
              ack_step <= ack_step + 5'h01;
            end
          end
        end
        default: begin
          proto <= P_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output selection

  wire in_trst    = ~s_reset_n;
  wire in_reset   = (status == ST_RESET);
  wire path_on    = bypass || (!in_trst && ((status == ST_ON) || (status == ST_MULTI)));
  wire tdo_on     = bypass || (!in_trst && (status == ST_ON));

  // Force-connect outranks only the reset status; with primary reset low mode select is still forced high
  wire next_tms   = (in_trst || (!bypass && in_reset)) ? 1'b1 :
                    path_on ? s_tms :
                    secondary_out.mode_select;
  wire next_sdo   = s_tdi;
  wire next_sdoe  = path_on;
  wire next_pdo   = tdo_on ? s_sdi : ack_bit;
  wire next_pdoe  = tdo_on || (!bypass && !in_trst && ack_oe);
  wire next_con_n = ~path_on;

  // Every output is a flop, so each path adds about three clk_in cycles of delay;
  // the link clock must stay well below clk_in for this to look combinational.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      secondary_out   <= '{clock: 1'b0, reset_n: 1'b0, mode_select: 1'b1,
                           data_out: 1'b0, data_out_oe: 1'b0};
      primary_out     <= '{data_out: 1'b0, data_out_oe: 1'b0};
      connected_n_out <= 1'b1;
    end else begin
      secondary_out.clock       <= s_clock;
      secondary_out.reset_n     <= s_reset_n;
      secondary_out.mode_select <= next_tms;
      secondary_out.data_out    <= next_sdo;
      secondary_out.data_out_oe <= next_sdoe;
      primary_out.data_out      <= next_pdo;
      primary_out.data_out_oe   <= next_pdoe;
      connected_n_out           <= next_con_n;
    end
  end

endmodule
`default_nettype wire

// ### hdl/asps_pkg.sv
package asps_pkg;

  localparam int          ADDR_W        = 10;
  localparam int          SYNC_W        = 14;
  localparam logic [9:0]  RESET_CODE    = 10'h3FF;
  localparam logic [9:0]  DISCONN_CODE  = 10'h3FE;
  localparam logic [9:0]  SYNC_CODE     = 10'h3FD;
  localparam logic [3:0]  LAST_BIT      = 4'h9;
  localparam logic [4:0]  ACK_STEPS     = 5'h14;
  localparam logic [9:0]  ADDR_RESET    = 10'h000;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } asps_tap_e;

  typedef enum {ST_RESET, ST_OFF, ST_ON, ST_MULTI} asps_status_e;

  typedef enum {P_IDLE, P_ADDR, P_ACK} asps_proto_e;

  typedef struct packed {
    logic clock;
    logic reset_n;
    logic mode_select;
    logic data_in;
  } asps_primary_in_s;

  typedef struct packed {
    logic data_out;
    logic data_out_oe;
  } asps_primary_out_s;

  typedef struct packed {
    logic clock;
    logic reset_n;
    logic mode_select;
    logic data_out;
    logic data_out_oe;
  } asps_secondary_out_s;

endpackage

// ### verification/asps_switch_sva.sv
`timescale 1ns/1ps
`default_nettype none
module asps_switch_sva #(
  parameter int ADDR_WIDTH = 10
) (
  input wire logic                          clk_in,
  input wire logic                          reset_n_in,
  input wire asps_pkg::asps_primary_in_s    primary_in,
  input wire logic                          secondary_data_in,
  input wire logic                          force_connect_n_in,
  input wire logic [ADDR_WIDTH-1:0]         board_address_straps_in,
  input wire asps_pkg::asps_primary_out_s   primary_out,
  input wire asps_pkg::asps_secondary_out_s secondary_out,
  input wire logic                          connected_n_out
);
  import asps_pkg::*;
  logic [2:0] live_cnt;
  logic [7:0] ack_cnt;
  wire        live = (live_cnt == 3'h5);

  // Pass-through checks wait until the synchronisers have flushed reset values
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      live_cnt <= 3'h0;
      ack_cnt  <= 8'h00;
    end else begin
      live_cnt <= live ? live_cnt : live_cnt + 3'h1;
      ack_cnt  <= (connected_n_out && primary_out.data_out_oe) ? ack_cnt + 8'h01 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_clock_pass: assert property (live |-> secondary_out.clock == $past(primary_in.clock, 3))
    else $error("secondary clock does not follow primary clock");
  chk_reset_pass: assert property (live |-> secondary_out.reset_n == $past(primary_in.reset_n, 3))
    else $error("secondary reset does not follow primary reset");
  chk_con_matches: assert property (
    live && $stable(connected_n_out) && $stable(secondary_out.data_out_oe)
    |-> connected_n_out == !secondary_out.data_out_oe)
    else $error("connect indicator disagrees with secondary drive");
  chk_sdo_path: assert property (
    live && secondary_out.data_out_oe && $past(secondary_out.data_out_oe, 3)
    |-> secondary_out.data_out == $past(primary_in.data_in, 3))
    else $error("secondary data out does not follow primary data in");
  chk_pdo_path: assert property (
    live && !connected_n_out && !$past(connected_n_out, 3) && primary_out.data_out_oe
    && $past(primary_out.data_out_oe, 3) |-> primary_out.data_out == $past(secondary_data_in, 3))
    else $error("primary data out does not follow secondary data in");
  chk_tms_reset_high: assert property (!primary_in.reset_n [*2] |-> ##3 secondary_out.mode_select)
    else $error("mode select not high under primary reset");
  chk_bypass_conn: assert property (
    !force_connect_n_in [*2] |-> ##3 (!connected_n_out && secondary_out.data_out_oe))
    else $error("bypass did not connect");
  chk_trst_float: assert property (
    (force_connect_n_in && !primary_in.reset_n) [*2] |-> ##3
    (connected_n_out && !secondary_out.data_out_oe && !primary_out.data_out_oe))
    else $error("primary reset did not disconnect");
  chk_ack_bounded: assert property (ack_cnt <= 8'hAA)
    else $error("primary data out driven too long while disconnected");
  chk_ack_on_fall: assert property (
    connected_n_out && $past(connected_n_out) && primary_out.data_out_oe
    && $past(primary_out.data_out_oe) && $changed(primary_out.data_out)
    |-> !$past(primary_in.clock, 2))
    else $error("acknowledge bit changed away from a falling edge");
endmodule

bind asps_switch asps_switch_sva #(.ADDR_WIDTH(ADDR_WIDTH)) i_sva (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .primary_in(primary_in),
  .secondary_data_in(secondary_data_in), .force_connect_n_in(force_connect_n_in),
  .board_address_straps_in(board_address_straps_in), .primary_out(primary_out),
  .secondary_out(secondary_out), .connected_n_out(connected_n_out));
`default_nettype wire

// ### verification/asps_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module asps_master_model (
  input  wire logic        pdo_in,
  input  wire logic        pdo_oe_in,
  output var  logic        tck_out,
  output var  logic        tms_out,
  output var  logic        tdi_out,
  output var  logic [19:0] ack_out,
  output var  logic [19:0] oe_out
);
  logic seen;
  initial begin
    {tck_out, tms_out, tdi_out, seen} = 4'h7;
    {ack_out, oe_out} = 40'h00_0000_0000;
  end

  // One test clock period; the clock stands still between calls
  // Pins move 1 ns after a system clock edge so no change races its sampling
  task automatic tick(input logic tms, input logic tdi);
    #1;
    tms_out = tms;
    tdi_out = tdi;
    #16 tck_out = 1'b1;
    // Sampled late in the cycle; a released line shows no stale value
    #28 seen = pdo_oe_in ? pdo_in : ~seen;
    ack_out = {ack_out[18:0], seen};
    oe_out = {oe_out[18:0], pdo_oe_in};
    #4 tck_out = 1'b0;
    #15;
  endtask

  // Start bit, complementary pairs MSB first, then time for the answer
  task automatic frame(input logic tms, input logic [9:0] code, input logic bad);
    tick(tms, 1'b1);
    tick(tms, 1'b0);
    for (int i = 9; i >= 0; i--) begin
      tick(tms, code[i]);
      tick(tms, (bad && i == 0) ? code[i] : ~code[i]);
    end
    repeat (20) tick(tms, 1'b1);
  endtask
endmodule
`default_nettype wire

// ### verification/asps_switch_bench.sv
`timescale 1ns/1ps
`default_nettype none
module asps_switch_bench;
  import asps_pkg::*;
  logic                  clk_in, reset_n_in, primary_test_reset_n_n, sdi, byp_n, tck, tms, tdi;
  logic [9:0]            straps;
  logic [19:0]           ack, ack_oe;
  asps_primary_out_s     pout;
  asps_secondary_out_s   sout;
  logic                  con_n;
  integer                seed = 22013;
  int                    error_cnt = 0;
  int                    total_checks = 0;
  wire asps_primary_in_s pin = {tck, primary_test_reset_n_n, tms, tdi};

  asps_switch #(.ADDR_WIDTH(10)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .primary_in(pin), .secondary_data_in(sdi), .force_connect_n_in(byp_n),
    .board_address_straps_in(straps), .primary_out(pout), .secondary_out(sout),
    .connected_n_out(con_n));
  asps_master_model i_master (.pdo_in(pout.data_out), .pdo_oe_in(pout.data_out_oe),
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .ack_out(ack), .oe_out(ack_oe));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compares {connected_n, secondary drive, primary drive} once settled
  task automatic state(input logic [2:0] exp);
    repeat (6) @(posedge clk_in);
    // Looked at mid-cycle, away from the edge that updates the outputs
    @(negedge clk_in);
    check("status", {17'h0_0000, exp}, {17'h0_0000, con_n, sout.data_out_oe, pout.data_out_oe});
    @(posedge clk_in);
  endtask
  task automatic ms(input logic exp);
    @(negedge clk_in);
    check("mode select", {19'h0_0000, exp}, {19'h0_0000, sout.mode_select});
    @(posedge clk_in);
  endtask
  function automatic logic [19:0] exp_ack(input logic [9:0] a);
    for (int i = 9; i >= 0; i--) exp_ack = {exp_ack[17:0], a[i], ~a[i]};
  endfunction
  task automatic connect(input logic tmsv);
    i_master.frame(tmsv, straps, 1'b0);
    check("ack bits", exp_ack(straps), ack);
    check("ack enable", 20'hF_FFFF, ack_oe);
    i_master.tick(tmsv, 1'b1);
    state(3'b011);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) sdi <= 1'($random(seed));
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end

  initial begin
    {reset_n_in, primary_test_reset_n_n, byp_n} = 3'h3;
    // Kept clear of the global codes, also after flipping bit 0
    straps = 10'($unsigned($random(seed)) % 1020);
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    state(3'b100);
    ms(1'b1);
    connect(1'b1);
    i_master.tick(1'b0, 1'b1);
    i_master.frame(1'b0, straps ^ 10'h001, 1'b0);
    check("no ack", 20'h0_0000, ack_oe);
    state(3'b100);
    repeat (3) i_master.tick(1'b1, 1'b1);
    ms(1'b0);
    connect(1'b1);
    i_master.frame(1'b1, DISCONN_CODE, 1'b0);
    state(3'b100);
    i_master.frame(1'b1, SYNC_CODE, 1'b0);
    state(3'b100);
    for (int i = 0; i < 5; i++) i_master.tick(1'(i % 2), 1'b1);
    i_master.frame(1'b0, SYNC_CODE, 1'b0);
    state(3'b010);
    i_master.frame(1'b0, RESET_CODE, 1'b0);
    state(3'b100);
    ms(1'b1);
    i_master.tick(1'b1, 1'b1);
    i_master.tick(1'b0, 1'b1);
    i_master.frame(1'b0, straps, 1'b0);
    check("shift ack", 20'h0_0000, ack_oe);
    state(3'b100);
    repeat (5) i_master.tick(1'b1, 1'b1);
    i_master.tick(1'b0, 1'b1);
    connect(1'b0);
    i_master.frame(1'b0, straps, 1'b1);
    state(3'b100);
    ms(1'b0);
    primary_test_reset_n_n <= 1'b0;
    state(3'b100);
    byp_n <= 1'b0;
    state(3'b011);
    ms(1'b1);
    primary_test_reset_n_n <= 1'b1;
    i_master.frame(1'b1, DISCONN_CODE, 1'b0);
    state(3'b011);
    byp_n <= 1'b1;
    state(3'b100);
    conclude();
  end
endmodule
`default_nettype wire
